// >>> ehp_pkg.sv
`default_nettype none
package ehp_pkg;
  // Register byte offsets on the bus.
  localparam int WB_AW = 8;
  localparam logic [7:0] OFS_MAC_CON = 8'h00;
  localparam logic [7:0] OFS_TX_CON = 8'h04;
  localparam logic [7:0] OFS_RX_CON = 8'h08;
  localparam logic [7:0] OFS_RX_PTR = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_TBL_EN = 8'h18;
  localparam logic [7:0] OFS_TBL = 8'h80;
  localparam int TBL_WORDS = 32;
  // Field positions.
  localparam int MC_FDX = 0;
  localparam int TC_TXEN = 0;
  localparam int TC_PAUSE = 1;
  localparam int RC_EN = 0;
  localparam int RC_STOP_NO = 1;
  localparam int NUM_EV = 4;
  localparam int EV_RX_DONE = 0;
  localparam int EV_NULL = 1;
  localparam int EV_NOT_OWN = 2;
  localparam int EV_PAUSE_DONE = 3;
  localparam int ST_PEND_BIT = 8;
  // Values after reset.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic RST_BIT = 1'b0;
  // Receive descriptor layout.
  localparam logic [31:0] DESC_BUF_OFS = 32'h0000_0000;
  localparam logic [31:0] DESC_STAT_OFS = 32'h0000_0008;
  localparam logic [31:0] DESC_NEXT_OFS = 32'h0000_000C;
  localparam int OWN_BIT = 31;
  localparam int RXS_ERR = 1;
  localparam int RXS_OVF = 2;
  localparam int RXS_LONG = 3;
  localparam int RXS_GOOD = 6;
  localparam logic [15:0] RX_BUF_BYTES = 16'h05F0;
  // Pause frame image: entries 0 to 2, then entries 27 and 28, then zero pad.
  localparam logic [5:0] PAUSE_HDR_BYTES = 6'h0C;
  localparam logic [5:0] PAUSE_DATA_END = 6'h12;
  localparam logic [5:0] PAUSE_LAST = 6'h3B;
  localparam logic [6:0] PAUSE_CTL_BASE = 7'h6C;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OWN_RD = 3'b001,
    ST_WAIT = 3'b010,
    ST_RECV = 3'b011,
    ST_STAT_WR = 3'b100,
    ST_OWN_WR = 3'b101,
    ST_NEXT_RD = 3'b110
  } ehp_rx_state_t;

  // Byte-enable merge of a bus write into a stored word.
  function automatic logic [31:0] ehp_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Table words hold station addresses most significant byte first.
  function automatic logic [7:0] ehp_byte_of(input logic [31:0] w,
                                             input logic [1:0] lane);
    return w[{2'd3 - lane, 3'b000} +: 8];
  endfunction
endpackage
`default_nettype wire

// >>> ehp_if.sv
`timescale 1ns/1ps
`default_nettype none
// Read port of the address table, used by the pause sender.
interface ehp_tbl_if;
  logic [4:0] idx;
  logic [31:0] word;
  modport tx (output idx, input word);
  modport tbl (input idx, output word);
endinterface

// Event, clear and mask lines between the engine and the interrupt block.
interface ehp_evt_if;
  logic [3:0] evt;
  logic [3:0] clr;
  logic [3:0] status;
  logic [3:0] mask;
  logic [3:0] mask_wdata;
  logic mask_we;
  logic irq;
  modport ctl (output evt, clr, mask_we, mask_wdata,
               input status, mask, irq);
  modport blk (input evt, clr, mask_we, mask_wdata,
               output status, mask, irq);
endinterface
`default_nettype wire

// >>> ehp_irq.sv
`timescale 1ns/1ps
`default_nettype none
module ehp_irq (
  input wire logic sys_clk,
  input wire logic rst,
  ehp_evt_if.blk ev
);
  import ehp_pkg::*;
  logic [3:0] status;
  logic [3:0] mask;
  logic irq;
  logic [3:0] next_status;
  logic [3:0] next_mask;
  logic next_irq;

  // A new event outranks a write-one clear of the same bit.
  always_comb begin
    next_status = (status & ~ev.clr) | ev.evt;
    next_mask = ev.mask_we ? ev.mask_wdata : mask;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= '0;
      mask <= '0;
      irq <= RST_BIT;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  assign ev.status = status;
  assign ev.mask = mask;
  assign ev.irq = irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  set_wins_a: assert property ((ev.evt & ev.clr) != 4'h0 |=>
    (status & $past(ev.evt & ev.clr)) == $past(ev.evt & ev.clr))
    else $error("event lost against a clear");
endmodule
`default_nettype wire

// >>> ehp_pause_tx.sv
`timescale 1ns/1ps
`default_nettype none
module ehp_pause_tx (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  ehp_tbl_if.tx tbl
);
  import ehp_pkg::*;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic next_busy;
  logic next_done;
  logic next_valid;
  logic next_last;
  logic [7:0] next_data;
  logic [6:0] tb;

  // Frame byte to table byte: header from entries 0 to 2, then entries 27 and 28.
  always_comb begin
    if (cnt < PAUSE_HDR_BYTES) begin
      tb = {1'b0, cnt};
    end else begin
      tb = PAUSE_CTL_BASE + {1'b0, cnt} - {1'b0, PAUSE_HDR_BYTES};
    end
  end
  assign tbl.idx = tb[6:2];

  // One byte a cycle; the tail past the control field is zero padding.
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_done = 1'b0;
    next_valid = 1'b0;
    next_last = 1'b0;
    next_data = 8'h00;
    if (!busy) begin
      if (start) begin
        next_busy = 1'b1;
        next_cnt = '0;
      end
    end else begin
      next_valid = 1'b1;
      if (cnt < PAUSE_DATA_END) begin
        next_data = ehp_byte_of(tbl.word, tb[1:0]);
      end
      if (cnt == PAUSE_LAST) begin
        next_last = 1'b1;
        next_done = 1'b1;
        next_busy = 1'b0;
      end else begin
        next_cnt = cnt + 6'd1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy <= RST_BIT;
      cnt <= '0;
      done <= RST_BIT;
      tx_valid <= RST_BIT;
      tx_last <= RST_BIT;
      tx_data <= 8'h00;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      done <= next_done;
      tx_valid <= next_valid;
      tx_last <= next_last;
      tx_data <= next_data;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  pause_length_a: assert property ($rose(busy) |-> ##60 (tx_last && done))
    else $error("pause frame not sixty bytes");
  pause_cov: cover property ($rose(busy) ##60 done);
endmodule
`default_nettype wire

// >>> ehp_rx_dma.sv
`timescale 1ns/1ps
`default_nettype none
module ehp_rx_dma (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ehp_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_err,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last
);
  import ehp_pkg::*;
  ehp_tbl_if tif();
  ehp_evt_if ev();
  logic [31:0] tbl [0:TBL_WORDS-1];
  logic fdx, tx_en, send_pause, rx_en, stop_no;
  logic next_fdx, next_tx_en, next_pause, next_rx_en, next_stop_no;
  logic [31:0] rx_ptr, tbl_en, next_ptr, next_tbl_en, rdata, wval;
  logic tx_busy, tx_done, tx_start, req, wr;
  logic [7:0] adr;
  logic [3:0] evt;
  ehp_rx_state_t state, next_state;
  logic [30:0] buf_a, next_buf;
  logic [15:0] len, next_len, woff, next_woff, rx_stat;
  logic [31:0] acc, next_acc, wbuf, next_wbuf;
  logic [1:0] lane, next_lane;
  logic wpend, next_wpend, lseen, next_lseen, err, next_err;
  logic ovf, next_ovf, miss, next_miss, mid, next_mid;
  logic fsm_stop, fsm_ptr_we, fstart, byte_ok;

  ehp_pause_tx u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(tx_start),
    .busy(tx_busy),
    .done(tx_done),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tbl(tif.tx)
  );

  ehp_irq u_irq (
    .sys_clk(sys_clk),
    .rst(rst),
    .ev(ev.blk)
  );

  assign adr = {wb_adr_i[7:2], 2'b00};
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign tif.word = tbl[tif.idx];
  assign irq = ev.irq;
  // Only a full-duplex link may carry a pause request to the sender.
  assign tx_start = send_pause && fdx && !tx_busy && !tx_done;
  assign ev.evt = evt;

  // Table storage is plain data and needs no reset.
  always_ff @(posedge sys_clk) begin
    if (wr && adr >= OFS_TBL) begin
      tbl[adr[6:2]] <= ehp_merge(tbl[adr[6:2]], wb_dat_i, wb_sel_i);
    end
  end

  // Control registers; a software write outranks a same-cycle hardware clear.
  always_comb begin
    next_fdx = fdx;
    next_tx_en = tx_en;
    next_pause = send_pause;
    next_rx_en = rx_en;
    next_stop_no = stop_no;
    next_ptr = rx_ptr;
    next_tbl_en = tbl_en;
    ev.clr = '0;
    ev.mask_we = 1'b0;
    ev.mask_wdata = wb_dat_i[NUM_EV-1:0];
    wval = '0;
    if (tx_done || !fdx) next_pause = 1'b0;
    if (fsm_stop) next_rx_en = 1'b0;
    if (fsm_ptr_we) next_ptr = mem_rdata;
    if (wr) begin
      case (adr)
        OFS_MAC_CON: begin
          wval = ehp_merge({31'd0, fdx}, wb_dat_i, wb_sel_i);
          next_fdx = wval[MC_FDX];
        end
        OFS_TX_CON: begin
          wval = ehp_merge({30'd0, send_pause, tx_en}, wb_dat_i, wb_sel_i);
          next_tx_en = wval[TC_TXEN];
          next_pause = wval[TC_PAUSE];
        end
        OFS_RX_CON: begin
          wval = ehp_merge({30'd0, stop_no, rx_en}, wb_dat_i, wb_sel_i);
          next_rx_en = wval[RC_EN];
          next_stop_no = wval[RC_STOP_NO];
        end
        OFS_RX_PTR: next_ptr = ehp_merge(rx_ptr, wb_dat_i, wb_sel_i);
        OFS_STAT: begin
          if (wb_sel_i[0]) ev.clr = wb_dat_i[NUM_EV-1:0];
        end
        OFS_MASK: ev.mask_we = wb_sel_i[0];
        OFS_TBL_EN: next_tbl_en = ehp_merge(tbl_en, wb_dat_i, wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped words answer with zero.
  always_comb begin
    rdata = '0;
    case (adr)
      OFS_MAC_CON: rdata[MC_FDX] = fdx;
      OFS_TX_CON: rdata[TC_PAUSE:TC_TXEN] = {send_pause, tx_en};
      OFS_RX_CON: rdata[RC_STOP_NO:RC_EN] = {stop_no, rx_en};
      OFS_RX_PTR: rdata = rx_ptr;
      OFS_STAT: begin
        rdata[NUM_EV-1:0] = ev.status;
        rdata[ST_PEND_BIT] = send_pause;
      end
      OFS_MASK: rdata[NUM_EV-1:0] = ev.mask;
      OFS_TBL_EN: rdata = tbl_en;
      default: if (adr >= OFS_TBL) rdata = tbl[adr[6:2]];
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fdx <= RST_BIT;
      tx_en <= RST_BIT;
      send_pause <= RST_BIT;
      rx_en <= RST_BIT;
      stop_no <= RST_BIT;
      rx_ptr <= RST_WORD;
      tbl_en <= RST_WORD;
      wb_ack_o <= RST_BIT;
      wb_dat_o <= RST_WORD;
    end else begin
      fdx <= next_fdx;
      tx_en <= next_tx_en;
      send_pause <= next_pause;
      rx_en <= next_rx_en;
      stop_no <= next_stop_no;
      rx_ptr <= next_ptr;
      tbl_en <= next_tbl_en;
      wb_ack_o <= req;
      wb_dat_o <= req ? rdata : RST_WORD;
    end
  end

  // Receive engine. The byte stream has no back-pressure, so a word that
  // completes while the previous write is still open marks an overflow.
  assign fstart = rx_valid && !mid;
  always_comb begin
    next_state = state;
    next_buf = buf_a;
    next_len = len;
    next_woff = woff;
    next_acc = acc;
    next_lane = lane;
    next_wbuf = wbuf;
    next_wpend = wpend;
    next_lseen = lseen;
    next_err = err;
    next_ovf = ovf;
    next_miss = miss;
    next_mid = rx_valid ? !rx_last : mid;
    evt = '0;
    fsm_stop = 1'b0;
    fsm_ptr_we = 1'b0;
    byte_ok = 1'b0;
    rx_stat = '0;
    rx_stat[RXS_ERR] = err;
    rx_stat[RXS_OVF] = ovf;
    rx_stat[RXS_LONG] = len > RX_BUF_BYTES;
    rx_stat[RXS_GOOD] = !err && !ovf && !(len > RX_BUF_BYTES);
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = rx_ptr;
    mem_wdata = '0;
    case (state)
      ST_IDLE: begin
        if (rx_en) begin
          if (rx_ptr == RST_WORD) begin
            evt[EV_NULL] = 1'b1;
            fsm_stop = 1'b1;
          end else if (!miss || fstart) begin
            next_state = ST_OWN_RD;
          end
        end
      end
      ST_OWN_RD: begin
        mem_req = 1'b1;
        mem_addr = rx_ptr + DESC_BUF_OFS;
        if (mem_ack) begin
          if (mem_rdata[OWN_BIT]) begin
            next_buf = mem_rdata[30:0];
            next_miss = 1'b0;
            next_state = ST_WAIT;
          end else begin
            evt[EV_NOT_OWN] = 1'b1;
            next_miss = 1'b1;
            fsm_stop = stop_no;
            next_state = ST_IDLE;
          end
        end
      end
      ST_WAIT: begin
        if (!rx_en) begin
          next_state = ST_IDLE;
        end else if (fstart) begin
          byte_ok = 1'b1;
          next_len = '0;
          next_woff = '0;
          next_lane = '0;
          next_acc = '0;
          next_err = 1'b0;
          next_ovf = 1'b0;
          next_lseen = 1'b0;
          next_state = ST_RECV;
        end
      end
      ST_RECV: begin
        byte_ok = rx_valid;
        mem_req = wpend;
        mem_we = 1'b1;
        mem_addr = {1'b0, buf_a} + {16'd0, woff};
        mem_wdata = wbuf;
        if (wpend && mem_ack) begin
          next_wpend = 1'b0;
          next_woff = woff + 16'd4;
        end
      end
      ST_STAT_WR: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
        mem_addr = rx_ptr + DESC_STAT_OFS;
        mem_wdata = {rx_stat, len};
        if (mem_ack) next_state = ST_OWN_WR;
      end
      ST_OWN_WR: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
        mem_wdata = {1'b0, buf_a};
        if (mem_ack) next_state = ST_NEXT_RD;
      end
      ST_NEXT_RD: begin
        mem_req = 1'b1;
        mem_addr = rx_ptr + DESC_NEXT_OFS;
        if (mem_ack) begin
          fsm_ptr_we = 1'b1;
          evt[EV_RX_DONE] = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Byte packing into little-endian words for the frame buffer.
    if (byte_ok) begin
      next_acc[{next_lane, 3'b000} +: 8] = rx_data;
      if (next_len != 16'hFFFF) next_len = next_len + 16'd1;
      if (rx_err) next_err = 1'b1;
      if (rx_last) next_lseen = 1'b1;
      if (next_lane == 2'd3 || rx_last) begin
        if (next_wpend) begin
          next_ovf = 1'b1;
        end else if (next_woff < RX_BUF_BYTES) begin
          next_wbuf = next_acc;
          next_wpend = 1'b1;
        end
        next_acc = '0;
        next_lane = '0;
      end else begin
        next_lane = next_lane + 2'd1;
      end
    end
    if (state == ST_RECV && next_lseen && !next_wpend) begin
      next_state = ST_STAT_WR;
    end
    evt[EV_PAUSE_DONE] = tx_done;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      buf_a <= '0;
      len <= '0;
      woff <= '0;
      acc <= RST_WORD;
      lane <= '0;
      wbuf <= RST_WORD;
      wpend <= RST_BIT;
      lseen <= RST_BIT;
      err <= RST_BIT;
      ovf <= RST_BIT;
      miss <= RST_BIT;
      mid <= RST_BIT;
    end else begin
      state <= next_state;
      buf_a <= next_buf;
      len <= next_len;
      woff <= next_woff;
      acc <= next_acc;
      lane <= next_lane;
      wbuf <= next_wbuf;
      wpend <= next_wpend;
      lseen <= next_lseen;
      err <= next_err;
      ovf <= next_ovf;
      miss <= next_miss;
      mid <= next_mid;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  null_list_a: assert property (state == ST_IDLE && rx_en &&
    rx_ptr == RST_WORD && !wr |=> !rx_en && ev.status[EV_NULL])
    else $error("null list not flagged");
  frame_irq_a: assert property (state == ST_NEXT_RD && mem_ack |=>
    ev.status[EV_RX_DONE] && state == ST_IDLE)
    else $error("frame done not flagged");
  w1c_clear_a: assert property (wr && adr == OFS_STAT && wb_sel_i[0] &&
    wb_dat_i[EV_RX_DONE] && !evt[EV_RX_DONE] |=> !ev.status[EV_RX_DONE])
    else $error("frame done flag not cleared");
  ptr_adv_a: assert property (state == ST_NEXT_RD && mem_ack &&
    !wr |=> rx_ptr == $past(mem_rdata))
    else $error("pointer not advanced");
  stat_len_a: assert property (state == ST_STAT_WR |->
    mem_wdata[15:0] == len && mem_wdata[16+RXS_GOOD] ==
    (!err && !ovf && len <= RX_BUF_BYTES))
    else $error("status word malformed");
  own_back_a: assert property (state == ST_OWN_WR && mem_ack |->
    !mem_wdata[OWN_BIT] ##1 state == ST_NEXT_RD)
    else $error("descriptor not handed back");
  stop_no_a: assert property (state == ST_OWN_RD && mem_ack &&
    !mem_rdata[OWN_BIT] && stop_no && !wr |=> !rx_en && ev.status[EV_NOT_OWN])
    else $error("stop on foreign descriptor failed");
  duplex_a: assert property (!fdx && !wr |=> !tx_start && !send_pause)
    else $error("pause allowed in half duplex");
  pending_a: assert property (tx_done && !wr |=> !send_pause)
    else $error("pending flag stuck after send");
  frame_cov: cover property (state == ST_RECV ##[1:200] state == ST_NEXT_RD);
  notown_cov: cover property (evt[EV_NOT_OWN]);
  irq_cov: cover property (irq && ev.status[EV_RX_DONE]);
endmodule
`default_nettype wire

// >>> ehp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ehp_mem_model (
  input wire logic sys_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:1023];
  logic slow = 1'b0;
  logic [1:0] wait_cnt = 2'b00;

  // Start quiet so the engine never sees a stray answer.
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
  end

  // Every other request is answered a cycle late, so both a prompt and a
  // slow memory are seen; stale read data is inverted, not held.
  always @(posedge sys_clk) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1) begin
      mem[mem_addr[11:2]] <= mem_wdata;
    end
    if (mem_req === 1'b1 && mem_ack !== 1'b1 &&
        wait_cnt >= {1'b0, slow}) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[11:2]];
      wait_cnt <= 2'b00;
      slow <= ~slow;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
        wait_cnt <= wait_cnt + 2'b01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ehp_pkg::*;
  localparam logic [143:0] HDR =
    144'h0011_2233_4455_6677_8899_AABB_8808_0001_1234;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, irq, mreq, mwe, mack, txv, txl;
  logic rxv = 1'b0;
  logic rxl = 1'b0;
  logic [7:0] rxd = 8'h00;
  logic rxe = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [31:0] maddr, mwd, mrd;
  logic [7:0] txd;
  logic [7:0] txq[$];
  int last_at = 0;
  int mismatches = 0;
  int cmp_count = 0;

  // Half period of 4 ns gives the 125 MHz core clock.
  always #4 sys_clk = ~sys_clk;

  ehp_rx_dma ehp_rx_dma_inst (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq),
    .rx_valid(rxv), .rx_data(rxd), .rx_last(rxl), .rx_err(rxe),
    .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwd),
    .mem_ack(mack), .mem_rdata(mrd), .tx_valid(txv), .tx_data(txd),
    .tx_last(txl));

  ehp_mem_model ehp_mem_model_inst (.sys_clk(sys_clk), .mem_req(mreq),
    .mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwd), .mem_ack(mack),
    .mem_rdata(mrd));

  // Pause bytes are recorded so the whole stream can be judged later.
  always @(posedge sys_clk) begin
    if (txv === 1'b1) begin
      txq.push_back(txd);
      if (txl === 1'b1) last_at = txq.size() - 1;
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        $display("ERROR %0t bus answer missing", $time);
        end_of_test();
      end
      @(posedge sys_clk);
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic send_frame(input int n, input logic e);
    for (int i = 0; i < n; i++) begin
      rxv <= 1'b1;
      rxd <= i[7:0];
      rxl <= (i == n - 1);
      rxe <= e;
      @(posedge sys_clk);
    end
    rxv <= 1'b0;
    rxl <= 1'b0;
    rxe <= 1'b0;
    rxd <= 8'hA5;
  endtask

  // Bounded wait for the receive interrupt; a hang ends in the report.
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      n++;
      if (n > 200) begin
        mismatches++;
        $display("ERROR %0t no receive interrupt", $time);
        end_of_test();
      end
      @(posedge sys_clk);
    end
  endtask

  task automatic t_reset();
    rd(OFS_STAT, 32'h0000_0000);
    rd(OFS_RX_PTR, 32'h0000_0000);
    sel <= 4'h1;
    wr(OFS_RX_PTR, 32'hFFFF_FF08);
    sel <= 4'hF;
    rd(OFS_RX_PTR, 32'h0000_0008);
    wr(OFS_RX_PTR, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
  endtask

  // A zero pointer with reception on must flag the empty list.
  task automatic t_null();
    wr(OFS_RX_CON, 32'h0000_0001);
    idle(10);
    rd(OFS_STAT, 32'h0000_0002);
    rd(OFS_RX_CON, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(OFS_MASK, 32'h0000_0002);
    idle(3);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(OFS_STAT, 32'h0000_0002);
    idle(3);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rd(OFS_STAT, 32'h0000_0000);
  endtask

  // One frame into a DMA-owned slot, then a CPU-owned slot stops it.
  // Eight bytes keep the last word a full word apart from the first, so a
  // slow memory answer cannot collide with it and look like an overflow.
  task automatic t_rx();
    ehp_mem_model_inst.mem[64] = 32'h8000_0400;
    ehp_mem_model_inst.mem[67] = 32'h0000_0200;
    ehp_mem_model_inst.mem[128] = 32'h0000_0600;
    wr(OFS_MASK, 32'h0000_0001);
    wr(OFS_RX_PTR, 32'h0000_0100);
    wr(OFS_RX_CON, 32'h0000_0003);
    idle(10);
    send_frame(8, 1'b0);
    wait_irq();
    idle(20);
    chk(ehp_mem_model_inst.mem[256], 32'h0302_0100);
    chk(ehp_mem_model_inst.mem[257], 32'h0706_0504);
    chk(ehp_mem_model_inst.mem[66], 32'h0040_0008);
    chk(ehp_mem_model_inst.mem[64], 32'h0000_0400);
    rd(OFS_RX_PTR, 32'h0000_0200);
    chk(ehp_mem_model_inst.mem[67], rdat);
    rd(OFS_STAT, 32'h0000_0005);
    rd(OFS_RX_CON, 32'h0000_0002);
    wr(OFS_STAT, 32'h0000_0005);
    rd(OFS_STAT, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
  endtask

  // The returned slot is polled again only at the next frame start, so that
  // frame is lost; the next one carries an error and ends at a zero link.
  task automatic t_rx_err();
    ehp_mem_model_inst.mem[128] = 32'h8000_0600;
    ehp_mem_model_inst.mem[131] = 32'h0000_0000;
    wr(OFS_RX_CON, 32'h0000_0001);
    idle(5);
    send_frame(4, 1'b0);
    idle(10);
    send_frame(8, 1'b1);
    wait_irq();
    idle(20);
    chk(ehp_mem_model_inst.mem[385], 32'h0706_0504);
    chk(ehp_mem_model_inst.mem[130], 32'h0002_0008);
    chk(ehp_mem_model_inst.mem[128], 32'h0000_0600);
    rd(OFS_RX_PTR, 32'h0000_0000);
    rd(OFS_STAT, 32'h0000_0003);
    rd(OFS_RX_CON, 32'h0000_0000);
    wr(OFS_STAT, 32'h0000_0003);
  endtask

  // Pause frame in full duplex, then a refused one in half duplex.
  task automatic t_pause();
    wr(OFS_TBL, 32'h0011_2233);
    wr(OFS_TBL + 8'h04, 32'h4455_6677);
    wr(OFS_TBL + 8'h08, 32'h8899_AABB);
    wr(OFS_TBL + 8'h6C, 32'h8808_0001);
    wr(OFS_TBL + 8'h70, 32'h1234_0000);
    for (int a = 8'hF4; a <= 8'hFC; a += 4) wr(a[7:0], 32'h0000_0000);
    wr(OFS_TBL_EN, 32'h001C_0003);
    wr(OFS_MAC_CON, 32'h0000_0001);
    wr(OFS_MASK, 32'h0000_0008);
    wr(OFS_TX_CON, 32'h0000_0003);
    rd(OFS_STAT, 32'h0000_0100);
    idle(80);
    rd(OFS_STAT, 32'h0000_0008);
    rd(OFS_TX_CON, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    chk(32'(txq.size()), 32'h0000_003C);
    for (int i = 0; i < 60; i++) begin
      chk({24'h00_0000, txq[i]},
          (i < 18) ? {24'h00_0000, HDR[8*(17-i) +: 8]} : 32'h0000_0000);
    end
    chk(32'(last_at), 32'h0000_003B);
    wr(OFS_STAT, 32'h0000_0008);
    wr(OFS_MAC_CON, 32'h0000_0000);
    wr(OFS_TX_CON, 32'h0000_0002);
    idle(10);
    rd(OFS_TX_CON, 32'h0000_0000);
    chk(32'(txq.size()), 32'h0000_003C);
  endtask

  // Main sequence: five cycles of reset, then each scenario in turn.
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_null();
    t_rx();
    t_rx_err();
    t_pause();
    end_of_test();
  end
endmodule
`default_nettype wire
